// [hdl/lcgs_map.svh]
`ifndef LCGS_MAP_SVH
`define LCGS_MAP_SVH

// Register offsets on the plain register port
`define LCGS_ADDR_G2_SEL 4'h0
`define LCGS_ADDR_G3_SEL 4'h1
`define LCGS_ADDR_STATUS 4'h2

// Select value loaded by power-on reset
`define LCGS_SEL_POR_VAL 8'h00

// Bit positions of the true and inverted enables for each channel
`define LCGS_CH1_TRUE_BIT 1
`define LCGS_CH1_INV_BIT 0
`define LCGS_CH2_TRUE_BIT 3
`define LCGS_CH2_INV_BIT 2
`define LCGS_CH3_TRUE_BIT 5
`define LCGS_CH3_INV_BIT 4
`define LCGS_CH4_TRUE_BIT 7
`define LCGS_CH4_INV_BIT 6

// Status register field positions
`define LCGS_STAT_GATE2_BIT 0
`define LCGS_STAT_GATE3_BIT 1

// Read data value for unmapped or idle cycles
`define LCGS_RD_IDLE_VAL 8'h00

`endif

// [hdl/lcgs_pkg.sv]
package lcgs_pkg;

   // Whole state of the top module, registered in one place
   typedef struct packed {
      logic [7:0] g2_sel;  // Gate 2 term select
      logic [7:0] g3_sel;  // Gate 3 term select
      logic [7:0] rd_data; // Read data, valid the cycle after a read
      logic gate2;         // Registered gate 2 result
      logic gate3;         // Registered gate 3 result
   } lcgs_state_type;

endpackage

// [hdl/lcgs_gate.sv]
`timescale 1ns/10ps
// OR of the enabled true and inverted data terms of one gate
module lcgs_gate #(
   parameter int CH_N = 4
) (
   // Term enables, one bit per channel
   input wire logic [CH_N-1:0] i_true_en,
   input wire logic [CH_N-1:0] i_inv_en,
   // Data channels
   input wire logic [CH_N-1:0] i_data,
   // Gate result
   output logic o_gate
);

   // No enabled term leaves the gate at zero
   always_comb begin
      o_gate = 1'b0; // R10
      for (int k = 0; k < CH_N; k++) begin
         // True form of the channel
         if (i_true_en[k] && i_data[k]) begin
            o_gate = 1'b1; // R10
         end
         // Inverted form of the channel
         if (i_inv_en[k] && !i_data[k]) begin
            o_gate = 1'b1; // R10
         end
      end
   end

endmodule

// [hdl/lcgs_top.sv]
`timescale 1ns/10ps
// Operation
// R01 - Gate 2: bit7 channel4 true, bit6 inverted
// R02 - Gate 2: bit5 channel3 true, bit4 inverted
// R03 - Gate 2: bit3 channel2 true, bit2 inverted
// R04 - Gate 2: bit1 channel1 true, bit0 inverted
// R05 - Gate 3: bit7 channel4 true, bit6 inverted
// R06 - Gate 3: bit5 channel3 true, bit4 inverted
// R07 - Gate 3: bit3 channel2 true, bit2 inverted
// R08 - Gate 3: bit1 channel1 true, bit0 inverted
// R09 - Selects read/write, kept through ordinary resets
// R10 - Gate ORs enabled terms, else zero
`include "lcgs_map.svh"

module lcgs_top import lcgs_pkg::*; #(
   parameter int ADDR_W = 4
) (
   // Clock, resets and enable
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_por,
   input wire logic i_clk_en,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rd_data,
   // Data channels from the source selectors
   input wire logic i_data_channel_1,
   input wire logic i_data_channel_2,
   input wire logic i_data_channel_3,
   input wire logic i_data_channel_4,
   // Gate results to the polarity stage
   output logic o_gate2,
   output logic o_gate3
);

   lcgs_state_type s_q; // Current state
   lcgs_state_type s_d; // Next state
   logic [3:0] data_vec; // Channels as one vector, channel 1 in bit 0
   logic [3:0] g2_true_en; // Gate 2 true enables per channel
   logic [3:0] g2_inv_en; // Gate 2 inverted enables per channel
   logic [3:0] g3_true_en; // Gate 3 true enables per channel
   logic [3:0] g3_inv_en; // Gate 3 inverted enables per channel
   logic gate2_c; // Combinational gate 2
   logic gate3_c; // Combinational gate 3
   logic hit_g2; // Address decodes gate 2 select
   logic hit_g3; // Address decodes gate 3 select
   logic hit_stat; // Address decodes status

   assign data_vec = {i_data_channel_4, i_data_channel_3, i_data_channel_2, i_data_channel_1};

   // Address decode, compared at the port width
   assign hit_g2 = (i_addr == ADDR_W'(`LCGS_ADDR_G2_SEL));
   assign hit_g3 = (i_addr == ADDR_W'(`LCGS_ADDR_G3_SEL));
   assign hit_stat = (i_addr == ADDR_W'(`LCGS_ADDR_STATUS));

   // Split gate 2 select into per-channel enables
   always_comb begin
      g2_true_en[3] = s_q.g2_sel[`LCGS_CH4_TRUE_BIT]; // R01
      g2_inv_en[3] = s_q.g2_sel[`LCGS_CH4_INV_BIT]; // R01
      g2_true_en[2] = s_q.g2_sel[`LCGS_CH3_TRUE_BIT]; // R02
      g2_inv_en[2] = s_q.g2_sel[`LCGS_CH3_INV_BIT]; // R02
      g2_true_en[1] = s_q.g2_sel[`LCGS_CH2_TRUE_BIT]; // R03
      g2_inv_en[1] = s_q.g2_sel[`LCGS_CH2_INV_BIT]; // R03
      g2_true_en[0] = s_q.g2_sel[`LCGS_CH1_TRUE_BIT]; // R04
      g2_inv_en[0] = s_q.g2_sel[`LCGS_CH1_INV_BIT]; // R04
   end

   // Split gate 3 select into per-channel enables
   always_comb begin
      g3_true_en[3] = s_q.g3_sel[`LCGS_CH4_TRUE_BIT]; // R05
      g3_inv_en[3] = s_q.g3_sel[`LCGS_CH4_INV_BIT]; // R05
      g3_true_en[2] = s_q.g3_sel[`LCGS_CH3_TRUE_BIT]; // R06
      g3_inv_en[2] = s_q.g3_sel[`LCGS_CH3_INV_BIT]; // R06
      g3_true_en[1] = s_q.g3_sel[`LCGS_CH2_TRUE_BIT]; // R07
      g3_inv_en[1] = s_q.g3_sel[`LCGS_CH2_INV_BIT]; // R07
      g3_true_en[0] = s_q.g3_sel[`LCGS_CH1_TRUE_BIT]; // R08
      g3_inv_en[0] = s_q.g3_sel[`LCGS_CH1_INV_BIT]; // R08
   end

   // Gate 2 term combiner
   lcgs_gate #(
      .CH_N(4)
   ) u_gate2 (
      .i_true_en(g2_true_en),
      .i_inv_en(g2_inv_en),
      .i_data(data_vec),
      .o_gate(gate2_c)
   );

   // Gate 3 term combiner
   lcgs_gate #(
      .CH_N(4)
   ) u_gate3 (
      .i_true_en(g3_true_en),
      .i_inv_en(g3_inv_en),
      .i_data(data_vec),
      .o_gate(gate3_c)
   );

   // Next state: register writes, read answer, gate sampling
   always_comb begin
      s_d = s_q;
      // Read data stands only in the cycle after the strobe
      s_d.rd_data = `LCGS_RD_IDLE_VAL;
      if (i_wr) begin
         // Write to a select register, other addresses ignored
         if (hit_g2) begin
            s_d.g2_sel = i_wr_data; // R09
         end
         if (hit_g3) begin
            s_d.g3_sel = i_wr_data; // R09
         end
      end
      if (i_rd) begin
         // Readback of the stored selects or the gate status
         if (hit_g2) begin
            s_d.rd_data = s_q.g2_sel; // R09
         end else if (hit_g3) begin
            s_d.rd_data = s_q.g3_sel; // R09
         end else if (hit_stat) begin
            s_d.rd_data[`LCGS_STAT_GATE2_BIT] = s_q.gate2;
            s_d.rd_data[`LCGS_STAT_GATE3_BIT] = s_q.gate3;
         end
      end
      // Registered so the polarity stage sees a clean edge
      s_d.gate2 = gate2_c; // R10
      s_d.gate3 = gate3_c; // R10
   end

   // State register; resets act even while the enable is low
   always_ff @(posedge i_clk_sys) begin
      if (i_por) begin
         // Power-on level loses everything, selects included
         s_q.g2_sel <= `LCGS_SEL_POR_VAL;
         s_q.g3_sel <= `LCGS_SEL_POR_VAL;
         s_q.rd_data <= `LCGS_RD_IDLE_VAL;
         s_q.gate2 <= 1'b0;
         s_q.gate3 <= 1'b0;
      end else if (i_rst) begin
         // Ordinary reset keeps software's selects
         s_q.g2_sel <= s_q.g2_sel; // R09
         s_q.g3_sel <= s_q.g3_sel; // R09
         s_q.rd_data <= `LCGS_RD_IDLE_VAL;
         s_q.gate2 <= 1'b0;
         s_q.gate3 <= 1'b0;
      end else if (i_clk_en) begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign o_rd_data = s_q.rd_data;
   assign o_gate2 = s_q.gate2;
   assign o_gate3 = s_q.gate3;

endmodule

// [verification/lcgs_checker.sv]
`timescale 1ns/10ps
`include "lcgs_map.svh"
// Port-level watcher for the gate select block
module lcgs_checker #(
   parameter int ADDR_W = 4
) (
   // Clock, resets, enable
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_por,
   input wire logic i_clk_en,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rd_data,
   // Channels and gates
   input wire logic i_data_channel_1,
   input wire logic i_data_channel_2,
   input wire logic i_data_channel_3,
   input wire logic i_data_channel_4,
   input wire logic o_gate2,
   input wire logic o_gate3
);
   logic [7:0] g2_q; // Shadow of gate 2 select
   logic [7:0] g3_q; // Shadow of gate 3 select
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst || i_por);
   // Shadow selects; ordinary reset keeps them, so only power-on clears
   always_ff @(posedge i_clk_sys) begin
      if (i_por) begin
         g2_q <= `LCGS_SEL_POR_VAL;
         g3_q <= `LCGS_SEL_POR_VAL;
      end else if (!i_rst && i_clk_en && i_wr && i_addr == `LCGS_ADDR_G2_SEL) begin
         g2_q <= i_wr_data;
      end else if (!i_rst && i_clk_en && i_wr && i_addr == `LCGS_ADDR_G3_SEL) begin
         g3_q <= i_wr_data;
      end
   end
   // Any enabled live term forces the gate high a cycle later
   property p_term(t, n, d, g);
      i_clk_en && ((t && d) || (n && !d)) |=> g;
   endproperty
   // Read strobe at a given offset
   sequence s_rd(a);
      i_clk_en && i_rd && i_addr == a;
   endsequence
   a_g2_ch4: assert property (p_term(g2_q[7], g2_q[6], i_data_channel_4, o_gate2)) else $error("g2 ch4");
   a_g2_ch3: assert property (p_term(g2_q[5], g2_q[4], i_data_channel_3, o_gate2)) else $error("g2 ch3");
   a_g2_ch2: assert property (p_term(g2_q[3], g2_q[2], i_data_channel_2, o_gate2)) else $error("g2 ch2");
   a_g2_ch1: assert property (p_term(g2_q[1], g2_q[0], i_data_channel_1, o_gate2)) else $error("g2 ch1");
   a_g3_ch4: assert property (p_term(g3_q[7], g3_q[6], i_data_channel_4, o_gate3)) else $error("g3 ch4");
   a_g3_ch3: assert property (p_term(g3_q[5], g3_q[4], i_data_channel_3, o_gate3)) else $error("g3 ch3");
   a_g3_ch2: assert property (p_term(g3_q[3], g3_q[2], i_data_channel_2, o_gate3)) else $error("g3 ch2");
   a_g3_ch1: assert property (p_term(g3_q[1], g3_q[0], i_data_channel_1, o_gate3)) else $error("g3 ch1");
   a_rd_g2: assert property (s_rd(`LCGS_ADDR_G2_SEL) |=> o_rd_data == g2_q) else $error("g2 readback");
   a_rd_g3: assert property (s_rd(`LCGS_ADDR_G3_SEL) |=> o_rd_data == g3_q) else $error("g3 readback");
   a_g2_none: assert property (i_clk_en && g2_q == 8'h00 |=> !o_gate2) else $error("g2 not zero");
   a_g3_none: assert property (i_clk_en && g3_q == 8'h00 |=> !o_gate3) else $error("g3 not zero");
endmodule

// [verification/tb.sv]
`timescale 1ns/10ps
`include "lcgs_map.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t: %h", $time, a); end end
// Self-checking bench for the gate select block
module tb;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic i_por = 1'b1;
   logic i_clk_en = 1'b1;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wr_data = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [3:0] dat = 4'h0; // Channels 4 down to 1
   logic [7:0] o_rd_data;
   logic o_gate2;
   logic o_gate3;
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   // Rows: gate 2 select, gate 3 select, channels, expected gates
   logic [21:0] rows [10] = '{{8'h80, 8'h40, 4'h8, 2'b10}, {8'h20, 8'h10, 4'h0, 2'b01},
      {8'h08, 8'h04, 4'h2, 2'b10}, {8'h02, 8'h01, 4'h0, 2'b01}, {8'h40, 8'h80, 4'h7, 2'b10},
      {8'h10, 8'h20, 4'h4, 2'b01}, {8'h04, 8'h08, 4'h0, 2'b10}, {8'h01, 8'h02, 4'h1, 2'b01},
      {8'h00, 8'h00, 4'hf, 2'b00}, {8'h55, 8'haa, 4'hf, 2'b01}};
   always #4 i_clk_sys = ~i_clk_sys;
   lcgs_top lcgs_top_inst (.i_clk_sys, .i_rst, .i_por, .i_clk_en, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
      .i_data_channel_1(dat[0]), .i_data_channel_2(dat[1]), .i_data_channel_3(dat[2]),
      .i_data_channel_4(dat[3]), .o_gate2, .o_gate3);
   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   // One-cycle read, data checked mid-cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(negedge i_clk_sys);
      `CHK(o_rd_data, e)
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hang guard, well above the fewer than 100 cycles needed
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      repeat (3) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      i_por <= 1'b0;
      foreach (rows[k]) begin
         wr(`LCGS_ADDR_G2_SEL, rows[k][21:14]);
         wr(`LCGS_ADDR_G3_SEL, rows[k][13:6]);
         dat <= rows[k][5:2];
         @(posedge i_clk_sys);
         @(negedge i_clk_sys);
         `CHK(o_gate2, rows[k][1])
         `CHK(o_gate3, rows[k][0])
         rd(`LCGS_ADDR_G2_SEL, rows[k][21:14]);
      end
      // Status shows the last row's gates; a write there is ignored
      rd(`LCGS_ADDR_STATUS, 8'h02);
      wr(`LCGS_ADDR_STATUS, 8'hff);
      rd(`LCGS_ADDR_STATUS, 8'h02);
      // Ordinary reset must keep the select
      wr(`LCGS_ADDR_G2_SEL, 8'ha5);
      i_rst <= 1'b1;
      @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rd(`LCGS_ADDR_G2_SEL, 8'ha5);
      // Write with clock enable low is dropped
      i_clk_en <= 1'b0;
      wr(`LCGS_ADDR_G3_SEL, 8'h3c);
      i_clk_en <= 1'b1;
      rd(`LCGS_ADDR_G3_SEL, 8'haa);
      // Power-on clears; unmapped offset reads zero
      i_por <= 1'b1;
      @(posedge i_clk_sys);
      i_por <= 1'b0;
      rd(`LCGS_ADDR_G2_SEL, `LCGS_SEL_POR_VAL);
      rd(4'hf, `LCGS_RD_IDLE_VAL);
      test_done();
   end
endmodule
bind lcgs_top lcgs_checker #(.ADDR_W(ADDR_W)) lcgs_checker_inst (.i_clk_sys, .i_rst, .i_por, .i_clk_en, .i_addr,
   .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_data_channel_1, .i_data_channel_2, .i_data_channel_3,
   .i_data_channel_4, .o_gate2, .o_gate3);
